// *** hw/wdit_pkg.sv ***
/*
  Shared constants and carrier types for the watchdog / interval timer.
  Assumes a 40 MHz system clock and an AXI4-Lite master with 8-bit
  addresses and 32-bit data.
*/
package wdit_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_COUNTER    = 8'h00;
  localparam logic [7:0] ADDR_CTRL       = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_WORD_MASK  = 8'hfc;

  // ************************************************************
  // Control/status fields and reset values
  // ************************************************************
  localparam int CTRL_FLAG_BIT   = 7;
  localparam int CTRL_MODE_BIT   = 6;
  localparam int CTRL_ENABLE_BIT = 5;
  localparam int CTRL_SOURCE_BIT = 4;
  localparam int CTRL_ACTION_BIT = 3;
  localparam int CTRL_CLKSEL_LSB = 0;
  localparam int CTRL_CLKSEL_W   = 3;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COUNTER_MAX   = 8'hff;

  // Protected write: key in byte lane 1, value in byte lane 0
  localparam int KEY_LSB = 8;
  localparam logic [7:0] KEY_COUNTER = 8'h5a;
  localparam logic [7:0] KEY_CTRL    = 8'ha5;

  // ************************************************************
  // Interrupt status / mask layout
  // ************************************************************
  localparam int IRQ_W            = 3;
  localparam int IRQ_INTERVAL_BIT = 0;
  localparam int IRQ_NMI_BIT      = 1;
  localparam int IRQ_RESET_BIT    = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ************************************************************
  // Prescalers
  // ************************************************************
  localparam int SYS_PRE_W = 17;
  localparam int SUB_PRE_W = 8;
  // Tap index per clock select code 7..0: /131072 .. /2
  localparam logic [7:0][4:0] SYS_TAP =
    {5'h10, 5'h0e, 5'h0c, 5'h0a, 5'h08, 5'h06, 5'h05, 5'h00};

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_OUT_NS  = 1000;
  localparam int RESET_OUT_CYCLES =
    (RESET_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CNT_W = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    WDIT_RP_IDLE   = 2'h1,
    WDIT_RP_ACTIVE = 2'h2
  } wdit_rp_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0]        awprot;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0]        arprot;
    logic              rready;
  } wdit_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wdit_axil_rsp_t;

endpackage : wdit_pkg

// *** hw/wdit_prescaler.sv ***
/*
  Free-running binary prescaler with one registered tick per stage.
  Assumes advance is synchronous to clk; tick[i] pulses once every
  2**(i+1) advances.
*/
`timescale 1ns/1ps
module wdit_prescaler #(
  parameter int WIDTH = 8
) (
  input  logic             clk,
  input  logic             reset_n,
  input  logic             advance,
  output logic [WIDTH-1:0] tick
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic [WIDTH-1:0] tick_ff;
  logic [WIDTH-1:0] nxt_tick;

  // ************************************************************
  // One tick per stage, each on the carry out of its bit
  // ************************************************************
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_tap
    assign nxt_tick[i] = advance & (&cnt_ff[i:0]);
  end

  always_comb
  begin
    nxt_cnt = advance ? cnt_ff + 1'b1 : cnt_ff;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_ff  <= '0;
      tick_ff <= '0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : wdit_prescaler

// *** hw/wdit_top.sv ***
/*
  Watchdog / interval timer channel with an AXI4-Lite register slave.
  Assumes one system clock, an asynchronous sub-clock on a pin that is
  much slower than CLK, and a single outstanding read and write.
*/
`timescale 1ns/1ps
module wdit_top #(
  parameter logic SUBCLOCK_CHANNEL = 1'b1
) (
  input  logic                    CLK,
  input  logic                    RESET_N,
  input  wdit_pkg::wdit_axil_req_t AXI_REQ,
  output wdit_pkg::wdit_axil_rsp_t AXI_RSP,
  input  logic                    EXT_SUBCLOCK_IN,
  output logic                    RESET_OUT_PIN_N,
  output logic                    INT_RESET_REQ,
  output logic                    NMI_REQ,
  output logic                    INTERVAL_OVERFLOW_IRQ
);

  // ************************************************************
  // Bus slave state
  // ************************************************************
  logic        aw_got_ff, nxt_aw_got;
  logic [7:0]  aw_addr_ff, nxt_aw_addr;
  logic        w_got_ff, nxt_w_got;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0]  w_strb_ff, nxt_w_strb;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic        do_write, ar_hs, wr_mapped, rd_mapped;
  logic [7:0]  wr_addr, rd_addr;
  logic [31:0] rd_value;
  logic        cnt_wr, ctrl_wr, sts_wr, mask_wr, ctrl_rd;

  // ************************************************************
  // Timer state
  // ************************************************************
  logic [7:0] counter_ff, nxt_counter;
  logic       flag_ff, nxt_flag;
  logic       flag_read_ff, nxt_flag_read;
  logic       mode_wd_ff, nxt_mode_wd;
  logic       enable_ff, nxt_enable;
  logic       source_ff, nxt_source;
  logic       action_rst_ff, nxt_action_rst;
  logic [2:0] clksel_ff, nxt_clksel;
  logic       sub_meta_ff, sub_sync_ff, sub_prev_ff, sub_edge;
  logic [wdit_pkg::SYS_PRE_W-1:0] sys_tick;
  logic [wdit_pkg::SUB_PRE_W-1:0] sub_tick;
  logic       sel_tick, count_tick, overflow_ev;
  logic       reset_ev, nmi_ev, interval_ev, sw_clear, en_clear;

  // ************************************************************
  // Reset pulse and interrupt state
  // ************************************************************
  wdit_pkg::wdit_rp_state_t rp_state_ff, nxt_rp_state;
  logic [wdit_pkg::RP_CNT_W-1:0] rp_count_ff, nxt_rp_count;
  logic [2:0] status_ff, nxt_status, mask_ff, nxt_mask;
  logic       nmi_ff, irq_ff, nxt_irq;

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  assign do_write  = aw_got_ff && w_got_ff && !bvalid_ff;
  assign ar_hs     = AXI_REQ.arvalid && !rvalid_ff;
  assign wr_addr   = aw_addr_ff & wdit_pkg::ADDR_WORD_MASK;
  assign rd_addr   = AXI_REQ.araddr & wdit_pkg::ADDR_WORD_MASK;
  assign wr_mapped = wr_addr <= wdit_pkg::ADDR_IRQ_MASK;
  assign rd_mapped = rd_addr <= wdit_pkg::ADDR_IRQ_MASK;

  // Counter and control take keyed writes only; an unkeyed write there is answered OKAY and dropped
  assign cnt_wr  = do_write && wr_addr == wdit_pkg::ADDR_COUNTER
                && w_strb_ff[1:0] == 2'h3
                && w_data_ff[15:8] == wdit_pkg::KEY_COUNTER;
  assign ctrl_wr = do_write && wr_addr == wdit_pkg::ADDR_CTRL
                && w_strb_ff[1:0] == 2'h3
                && w_data_ff[15:8] == wdit_pkg::KEY_CTRL;
  assign sts_wr  = do_write && wr_addr == wdit_pkg::ADDR_IRQ_STATUS
                && w_strb_ff[0];
  assign mask_wr = do_write && wr_addr == wdit_pkg::ADDR_IRQ_MASK
                && w_strb_ff[0];
  assign ctrl_rd = ar_hs && rd_addr == wdit_pkg::ADDR_CTRL;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (rd_addr)
      wdit_pkg::ADDR_COUNTER:    rd_value[7:0] = counter_ff;
      wdit_pkg::ADDR_CTRL:       rd_value[7:0] = {flag_ff, mode_wd_ff,
                                   enable_ff, source_ff, action_rst_ff,
                                   clksel_ff};
      wdit_pkg::ADDR_IRQ_STATUS: rd_value[2:0] = status_ff;
      wdit_pkg::ADDR_IRQ_MASK:   rd_value[2:0] = mask_ff;
      default:                   rd_value = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    nxt_aw_got  = aw_got_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_got   = w_got_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (AXI_REQ.awvalid && !aw_got_ff)
    begin
      nxt_aw_got  = 1'b1;
      nxt_aw_addr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && !w_got_ff)
    begin
      nxt_w_got  = 1'b1;
      nxt_w_data = AXI_REQ.wdata;
      nxt_w_strb = AXI_REQ.wstrb;
    end
    if (do_write)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_mapped ? wdit_pkg::RESP_OKAY : wdit_pkg::RESP_DECERR;
    end
    else if (bvalid_ff && AXI_REQ.bready)
    begin
      nxt_bvalid = 1'b0;
    end
    if (ar_hs)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_value;
      nxt_rresp  = rd_mapped ? wdit_pkg::RESP_OKAY : wdit_pkg::RESP_DECERR;
    end
    else if (rvalid_ff && AXI_REQ.rready)
    begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_got_ff   <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'h0;
    end
    else
    begin
      aw_got_ff  <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff   <= nxt_w_got;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign AXI_RSP.awready = !aw_got_ff;
  assign AXI_RSP.wready  = !w_got_ff;
  assign AXI_RSP.bvalid  = bvalid_ff;
  assign AXI_RSP.bresp   = bresp_ff;
  assign AXI_RSP.arready = !rvalid_ff;
  assign AXI_RSP.rvalid  = rvalid_ff;
  assign AXI_RSP.rdata   = rdata_ff;
  assign AXI_RSP.rresp   = rresp_ff;

  // ************************************************************
  // Prescalers and clock selection
  // ************************************************************
  // Sub-clock is sampled, so it must stay well below half of CLK
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sub_meta_ff <= 1'b0;
      sub_sync_ff <= 1'b0;
      sub_prev_ff <= 1'b0;
    end
    else
    begin
      sub_meta_ff <= EXT_SUBCLOCK_IN;
      sub_sync_ff <= sub_meta_ff;
      sub_prev_ff <= sub_sync_ff;
    end
  end
  assign sub_edge = sub_sync_ff && !sub_prev_ff;

  wdit_prescaler #(.WIDTH(wdit_pkg::SYS_PRE_W)) u_sys_pre (
    .clk     (CLK),
    .reset_n (RESET_N),
    .advance (1'b1),
    .tick    (sys_tick)
  );

  wdit_prescaler #(.WIDTH(wdit_pkg::SUB_PRE_W)) u_sub_pre (
    .clk     (CLK),
    .reset_n (RESET_N),
    .advance (sub_edge),
    .tick    (sub_tick)
  );

  // Sub-clock table is /2../256 by code, so its tap equals the code
  assign sel_tick = (SUBCLOCK_CHANNEL && source_ff)
                  ? sub_tick[clksel_ff]
                  : sys_tick[wdit_pkg::SYS_TAP[clksel_ff]];

  // ************************************************************
  // Counter, flag and control
  // ************************************************************
  assign count_tick  = enable_ff && sel_tick;
  assign overflow_ev = count_tick && !cnt_wr
                    && counter_ff == wdit_pkg::COUNTER_MAX;
  assign reset_ev    = overflow_ev && mode_wd_ff && action_rst_ff;
  assign nmi_ev      = overflow_ev && mode_wd_ff && !action_rst_ff;
  assign interval_ev = overflow_ev && !mode_wd_ff;
  assign sw_clear    = ctrl_wr && flag_read_ff
                    && !w_data_ff[wdit_pkg::CTRL_FLAG_BIT];
  assign en_clear    = ctrl_wr && !w_data_ff[wdit_pkg::CTRL_ENABLE_BIT];

  always_comb
  begin
    nxt_counter    = counter_ff;
    nxt_mode_wd    = mode_wd_ff;
    nxt_enable     = enable_ff;
    nxt_source     = source_ff;
    nxt_action_rst = action_rst_ff;
    nxt_clksel     = clksel_ff;
    nxt_flag       = flag_ff;
    nxt_flag_read  = flag_read_ff;
    // A keyed write beats a count-up in the same cycle
    if (!enable_ff)
      nxt_counter = wdit_pkg::COUNTER_RESET;
    else if (cnt_wr)
      nxt_counter = w_data_ff[7:0];
    else if (count_tick)
      nxt_counter = counter_ff + 8'h01;
    if (ctrl_wr)
    begin
      nxt_mode_wd    = w_data_ff[wdit_pkg::CTRL_MODE_BIT];
      nxt_enable     = w_data_ff[wdit_pkg::CTRL_ENABLE_BIT];
      nxt_action_rst = w_data_ff[wdit_pkg::CTRL_ACTION_BIT];
      nxt_clksel     = w_data_ff[wdit_pkg::CTRL_CLKSEL_LSB +:
                                 wdit_pkg::CTRL_CLKSEL_W];
      // Channel zero keeps bit 4 reserved at zero
      nxt_source     = SUBCLOCK_CHANNEL
                     && w_data_ff[wdit_pkg::CTRL_SOURCE_BIT];
    end
    if (sw_clear || en_clear || reset_ev)
      nxt_flag = 1'b0;
    if (nmi_ev || interval_ev)
      nxt_flag = 1'b1;
    if (ctrl_rd && flag_ff)
      nxt_flag_read = 1'b1;
    if (!nxt_flag)
      nxt_flag_read = 1'b0;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      counter_ff    <= wdit_pkg::COUNTER_RESET;
      flag_ff       <= wdit_pkg::CTRL_RESET[wdit_pkg::CTRL_FLAG_BIT];
      flag_read_ff  <= 1'b0;
      mode_wd_ff    <= wdit_pkg::CTRL_RESET[wdit_pkg::CTRL_MODE_BIT];
      enable_ff     <= wdit_pkg::CTRL_RESET[wdit_pkg::CTRL_ENABLE_BIT];
      source_ff     <= wdit_pkg::CTRL_RESET[wdit_pkg::CTRL_SOURCE_BIT];
      action_rst_ff <= wdit_pkg::CTRL_RESET[wdit_pkg::CTRL_ACTION_BIT];
      clksel_ff     <= wdit_pkg::CTRL_RESET[2:0];
    end
    else
    begin
      counter_ff    <= nxt_counter;
      flag_ff       <= nxt_flag;
      flag_read_ff  <= nxt_flag_read;
      mode_wd_ff    <= nxt_mode_wd;
      enable_ff     <= nxt_enable;
      source_ff     <= nxt_source;
      action_rst_ff <= nxt_action_rst;
      clksel_ff     <= nxt_clksel;
    end
  end

  // ************************************************************
  // Reset pulse, NMI and interrupt
  // ************************************************************
  always_comb
  begin
    nxt_rp_state = rp_state_ff;
    nxt_rp_count = rp_count_ff;
    nxt_status   = status_ff & ~(sts_wr ? w_data_ff[2:0] : 3'h0);
    nxt_mask     = mask_wr ? w_data_ff[2:0] : mask_ff;
    case (rp_state_ff)
      wdit_pkg::WDIT_RP_IDLE:
        nxt_rp_count = '0;
      wdit_pkg::WDIT_RP_ACTIVE:
        if (rp_count_ff == wdit_pkg::RP_CNT_W'(
                             wdit_pkg::RESET_OUT_CYCLES - 1))
        begin
          nxt_rp_state = wdit_pkg::WDIT_RP_IDLE;
          nxt_rp_count = '0;
        end
        else
          nxt_rp_count = rp_count_ff + 1'b1;
      default:
        nxt_rp_state = wdit_pkg::WDIT_RP_IDLE;
    endcase
    // A new overflow restarts the pulse
    if (reset_ev)
    begin
      nxt_rp_state = wdit_pkg::WDIT_RP_ACTIVE;
      nxt_rp_count = '0;
    end
    // Events set after the clear so a same-cycle set wins
    nxt_status[wdit_pkg::IRQ_INTERVAL_BIT] =
      nxt_status[wdit_pkg::IRQ_INTERVAL_BIT] | interval_ev;
    nxt_status[wdit_pkg::IRQ_NMI_BIT] =
      nxt_status[wdit_pkg::IRQ_NMI_BIT] | nmi_ev;
    nxt_status[wdit_pkg::IRQ_RESET_BIT] =
      nxt_status[wdit_pkg::IRQ_RESET_BIT] | reset_ev;
    nxt_irq = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rp_state_ff <= wdit_pkg::WDIT_RP_IDLE;
      rp_count_ff <= '0;
      status_ff   <= wdit_pkg::IRQ_RESET;
      mask_ff     <= wdit_pkg::IRQ_RESET;
      nmi_ff      <= 1'b0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      rp_state_ff <= nxt_rp_state;
      rp_count_ff <= nxt_rp_count;
      status_ff   <= nxt_status;
      mask_ff     <= nxt_mask;
      nmi_ff      <= nmi_ev;
      irq_ff      <= nxt_irq;
    end
  end

  assign RESET_OUT_PIN_N       = rp_state_ff != wdit_pkg::WDIT_RP_ACTIVE;
  assign INT_RESET_REQ         = rp_state_ff == wdit_pkg::WDIT_RP_ACTIVE;
  assign NMI_REQ               = nmi_ff;
  assign INTERVAL_OVERFLOW_IRQ = irq_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_reset_held;
    (!RESET_OUT_PIN_N && INT_RESET_REQ)[*8];
  endsequence

  property p_reset_pulse;
    reset_ev |=> s_reset_held;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset pin not held low after reset overflow");

  property p_reset_clears_flag;
    reset_ev |=> !flag_ff && !NMI_REQ;
  endproperty
  a_reset_clears_flag: assert property (p_reset_clears_flag)
    else $error("flag set or NMI raised on reset overflow");

  property p_nmi_pulse;
    nmi_ev |=> NMI_REQ && RESET_OUT_PIN_N && flag_ff ##1 !NMI_REQ;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse)
    else $error("NMI overflow did not give a single NMI pulse");

  property p_interval;
    interval_ev |=> status_ff[wdit_pkg::IRQ_INTERVAL_BIT] && flag_ff
                    && !NMI_REQ && RESET_OUT_PIN_N;
  endproperty
  a_interval: assert property (p_interval)
    else $error("interval overflow not flagged");

  property p_disabled_zero;
    !enable_ff |=> counter_ff == 8'h00;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero)
    else $error("counter not zero while disabled");

  property p_count_up;
    count_tick && !cnt_wr |=> counter_ff == 8'($past(counter_ff) + 8'h01);
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not advance by one");

  property p_flag_fall;
    $fell(flag_ff) |-> $past(sw_clear || en_clear || reset_ev);
  endproperty
  a_flag_fall: assert property (p_flag_fall)
    else $error("flag cleared without a clearing cause");

  property p_enable_clear;
    en_clear && !nmi_ev && !interval_ev |=> !flag_ff;
  endproperty
  a_enable_clear: assert property (p_enable_clear)
    else $error("disabling did not clear the flag");

  property p_unkeyed_hold;
    do_write && !cnt_wr && enable_ff && !count_tick
      |=> $stable(counter_ff);
  endproperty
  a_unkeyed_hold: assert property (p_unkeyed_hold)
    else $error("counter changed without keyed write");

endmodule : wdit_top

// *** bench/testbench.sv ***
/*
  Self-checking bench for the watchdog / interval timer channel.
  Assumes the register map, keys and reset pulse length of wdit_pkg.
*/
`timescale 1ns/1ps
module testbench;
  logic                     clk;
  logic                     reset_n;
  wdit_pkg::wdit_axil_req_t req;
  wdit_pkg::wdit_axil_rsp_t rsp;
  logic                     rst_pin_n;
  logic                     int_rst;
  logic                     nmi;
  logic                     irq;
  logic                     subclk;
  logic [31:0]              rd;
  logic [1:0]               resp;
  int                       num_errors = 0;
  int                       total_checks = 0;
  int                       i;

  wdit_top u_wdit_top (
    .CLK                   (clk),
    .RESET_N               (reset_n),
    .AXI_REQ               (req),
    .AXI_RSP               (rsp),
    .EXT_SUBCLOCK_IN       (subclk),
    .RESET_OUT_PIN_N       (rst_pin_n),
    .INT_RESET_REQ         (int_rst),
    .NMI_REQ               (nmi),
    .INTERVAL_OVERFLOW_IRQ (irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ************************************************************
  // Bus and check helpers
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // Ready is sampled mid-cycle, so the next rising edge takes the item;
  // bready and rready stay high for the whole run
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, done;
    done = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    while (!done)
    begin
      @(negedge clk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      done = (rsp.bvalid === 1'b1);
      resp = rsp.bresp;
      @(posedge clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
    end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    logic ta, done;
    done = 1'b0;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    while (!done)
    begin
      @(negedge clk);
      ta = req.arvalid && rsp.arready;
      done = (rsp.rvalid === 1'b1);
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk);
      if (ta) req.arvalid <= 1'b0;
    end
  endtask : axr

  task automatic wr_ctrl(input logic [7:0] v);
    axw(wdit_pkg::ADDR_CTRL, {16'h0000, wdit_pkg::KEY_CTRL, v});
  endtask : wr_ctrl

  // Park on the slowest tap, preload, then run on the /2 tap
  task automatic arm(input logic [7:0] bits);
    wr_ctrl(8'h27 | bits);
    axw(wdit_pkg::ADDR_COUNTER, {16'h0000, wdit_pkg::KEY_COUNTER, 8'hf0});
    axr(wdit_pkg::ADDR_COUNTER);
    chk("counter", rd, 32'h0000_00f0);
    wr_ctrl(8'h20 | bits);
  endtask : arm

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_values;
    axr(wdit_pkg::ADDR_CTRL);
    chk("ctrl reset", rd, 32'h0000_0000);
    axr(wdit_pkg::ADDR_COUNTER);
    chk("counter reset", rd, 32'h0000_0000);
    axr(8'h10);
    chk("unmapped resp", {30'h0, resp}, 32'h0000_0003);
    chk("unmapped data", rd, 32'h0000_0000);
    axw(8'h10, 32'h0000_0000);
    chk("unmapped wr resp", {30'h0, resp}, 32'h0000_0003);
  endtask : t_reset_values

  task automatic t_interval;
    axw(wdit_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    arm(8'h00);
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    chk("interval irq", irq, 1'b1);
    axr(wdit_pkg::ADDR_CTRL);
    chk("flag set", rd, 32'h0000_00a0);
    wr_ctrl(8'ha0);
    axr(wdit_pkg::ADDR_CTRL);
    chk("flag write one", rd, 32'h0000_00a0);
    wr_ctrl(8'h20);
    axr(wdit_pkg::ADDR_CTRL);
    chk("flag cleared", rd, 32'h0000_0020);
    axr(wdit_pkg::ADDR_IRQ_STATUS);
    chk("status interval", rd, 32'h0000_0001);
    axw(wdit_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    chk("irq cleared", irq, 1'b0);
  endtask : t_interval

  task automatic t_nmi;
    arm(8'h40);
    for (i = 0; i < 100 && nmi !== 1'b1; i++) @(negedge clk);
    chk("nmi pulse", nmi, 1'b1);
    @(negedge clk);
    chk("nmi one cycle", nmi, 1'b0);
    @(posedge clk);
    chk("reset pin idle", rst_pin_n, 1'b1);
    chk("irq masked", irq, 1'b0);
    // Flag not yet read as set, so a zero write must leave it
    wr_ctrl(8'h60);
    axr(wdit_pkg::ADDR_CTRL);
    chk("flag kept unread", rd, 32'h0000_00e0);
    axr(wdit_pkg::ADDR_CTRL);
    chk("flag second poll", rd, 32'h0000_00e0);
    axr(wdit_pkg::ADDR_IRQ_STATUS);
    chk("status nmi", rd, 32'h0000_0002);
    axw(wdit_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    wr_ctrl(8'h00);
    axr(wdit_pkg::ADDR_CTRL);
    chk("disable clears flag", rd, 32'h0000_0000);
    axr(wdit_pkg::ADDR_COUNTER);
    chk("disable zeroes", rd, 32'h0000_0000);
  endtask : t_nmi

  task automatic t_int_reset;
    arm(8'h48);
    for (i = 0; i < 100 && rst_pin_n !== 1'b0; i++) @(negedge clk);
    chk("reset pin low", rst_pin_n, 1'b0);
    chk("internal reset", int_rst, 1'b1);
    for (i = 0; i < 200 && rst_pin_n === 1'b0; i++) @(negedge clk);
    chk("pulse cycles", i, wdit_pkg::RESET_OUT_CYCLES);
    @(posedge clk);
    axr(wdit_pkg::ADDR_CTRL);
    chk("flag auto clear", rd, 32'h0000_0068);
    axr(wdit_pkg::ADDR_IRQ_STATUS);
    chk("status reset", rd, 32'h0000_0004);
    wr_ctrl(8'h00);
    axw(wdit_pkg::ADDR_CTRL, 32'h0000_0020);
    chk("unkeyed resp", {30'h0, resp}, 32'h0000_0000);
    axr(wdit_pkg::ADDR_CTRL);
    chk("unkeyed dropped", rd, 32'h0000_0000);
  endtask : t_int_reset

  // Four sub-clock rising edges on the /2 tap give two counts
  task automatic t_subclock;
    wr_ctrl(8'h30);
    axw(wdit_pkg::ADDR_COUNTER, {16'h0000, wdit_pkg::KEY_COUNTER, 8'h10});
    repeat (4)
    begin
      subclk <= 1'b1;
      repeat (4) @(posedge clk);
      subclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    axr(wdit_pkg::ADDR_COUNTER);
    chk("subclock count", rd, 32'h0000_0012);
    wr_ctrl(8'h00);
  endtask : t_subclock

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial
  begin
    reset_n = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    subclk = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_interval();
    t_nmi();
    t_int_reset();
    t_subclock();
    tally_and_finish();
  end

  // Whole run needs a few hundred cycles; this leaves wide margin
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : testbench
